// ==== core/bfps_phase.sv ====
// One switching phase: high-side on-time latch with pulse-by-pulse current limit
`timescale 1ns/1ps
module bfps_phase (
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  input  wire logic start_in,
  input  wire logic switch_in,
  input  wire logic over_limit_in,
  input  wire logic pwm_end_in,
  output logic      hs_on_out,
  output logic      term_out
);

  logic hs_on_nxt;
  logic term_nxt;

  // ==========================================================================
  // On-time control
  always_comb begin
    hs_on_nxt = hs_on_out;
    term_nxt  = 1'b0;
    if (!switch_in) begin
      hs_on_nxt = 1'b0;
    end else if (start_in) begin
      hs_on_nxt = 1'b1;
    end else if (hs_on_out && over_limit_in) begin
      hs_on_nxt = 1'b0; // RULE1
      term_nxt  = 1'b1; // RULE2
    end else if (hs_on_out && pwm_end_in) begin
      hs_on_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      hs_on_out <= 1'b0;
      term_out  <= 1'b0;
    end else begin
      hs_on_out <= hs_on_nxt;
      term_out  <= term_nxt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_limit_ends_cycle: assert property ( // RULE1
    switch_in && !start_in && hs_on_out && over_limit_in |=> term_out && !hs_on_out)
    else $error("over limit did not end the on-time");

  chk_limit_each_cycle: assert property ( // RULE2
    switch_in && start_in ##1 switch_in && !start_in && over_limit_in |=> term_out && !hs_on_out)
    else $error("persistent over limit not terminated in next cycle");

endmodule

// ==== core/bfps_pkg.sv ====
// Shared constants, register map and state encoding for the buck fault sequencer
package bfps_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_PERIOD      = 4'h4;
  localparam logic [3:0]  REG_STATUS      = 4'h8;
  localparam logic [3:0]  REG_EVENTS      = 4'hC;

  // ==========================================================================
  // Field positions
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_SYNC_BIT   = 1;
  localparam int          CTRL_DIV_LSB    = 4;
  localparam int          STAT_CNT_LSB    = 8;
  localparam int          STAT_PG_BIT     = 11;
  localparam int          STAT_EN_BIT     = 12;
  localparam int          EVT_OC1_BIT     = 0;
  localparam int          EVT_OC2_BIT     = 1;
  localparam int          EVT_OV_BIT      = 2;
  localparam int          EVT_UV_BIT      = 3;
  localparam int          EVT_SF_BIT      = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  CTRL_RST        = 8'h81;
  localparam logic [15:0] PERIOD_RST      = 16'h0028;

  // ==========================================================================
  // Counts and timing
  localparam logic [5:0]  SENSE_CHECK_CYCLES = 6'h20;
  localparam logic [2:0]  HICCUP_CYCLES      = 3'h7;
  localparam int          CLK_PERIOD_NS      = 50;
  localparam int          EN_OFF_TIME_NS     = 2000;
  localparam int          EN_OFF_CYCLES_I    = (EN_OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  EN_OFF_CYCLES      = EN_OFF_CYCLES_I[7:0];

  // ==========================================================================
  // Sequencer states
  typedef enum logic [7:0] {
    ST_OFF     = 8'h01,
    ST_INPUT_UNDERVOLTAGE_LOCKOUT    = 8'h02,
    ST_SENSE   = 8'h04,
    ST_SFAULT  = 8'h08,
    ST_SOFT    = 8'h10,
    ST_RUN     = 8'h20,
    ST_HIC_CHG = 8'h40,
    ST_HIC_DIS = 8'h80
  } bfps_state_e;

endpackage

// ==== core/bfps_sequencer.sv ====
// Fault supervision and startup sequencing for a two-phase interleaved buck
// How it works
// [RULE1] Current over limit on a phase ends that phase's on-time only.
// [RULE2] Persistent over limit on both phases terminates every cycle of both.
// [RULE3] Output undervoltage stops switching and starts hiccup charge/discharge timing.
// [RULE4] After seven hiccup cycles a new soft-start runs; a fault returns to hiccup.
// [RULE5] First 32 clocks after start: test current on, either sense pin high faults.
// [RULE6] Sense check runs only in initialization, never once switching starts.
// [RULE7] Overvoltage trip forces all upper switches off and lower switches on.
// [RULE8] Overvoltage runs seven hiccup cycles then restarts, re-entering hiccup if present; ST_SOFT keeps hic_cnt_r, so a re-entry runs one cycle.
// [RULE9] Feedback undervoltage enters the same hiccup sequence.
// [RULE10] Startup waits for the input undervoltage comparator to report above threshold.
// [RULE11] Startup waits until both supply rails are reported good.
// [RULE12] While soft-start is below completion, most faults ignored and power good low.
// [RULE13] Masked state keeps current limit, has no sense check, and enters hiccup only on overvoltage.
// [RULE14] Input undervoltage lockout holds upper off and lower on.
// [RULE15] A declared sense fault holds upper off and lower on.
// [RULE16] External sync falling edge starts the high-side on-time; clock must be fast enough.
// [RULE17] Phases are interleaved half a period apart, doubling ripple frequency.
// [RULE18] Soft-start charges only with enable high and rails good; power good low.
// [RULE19] Power good is released only when soft-start reaches completion.
// [RULE20] A clean soft-start completion clears the hiccup counter.
// [RULE21] Enable low or supply lockout turns both switches of each phase off.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module bfps_sequencer (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        en_sync_in,
  input  wire logic        device_supply_rail_ok_in,
  input  wire logic        bypass_supply_rail_ok_in,
  input  wire logic        input_undervoltage_lockout_ok_in,
  input  wire logic        phase1_over_limit_in,
  input  wire logic        phase2_over_limit_in,
  input  wire logic        phase1_pwm_end_in,
  input  wire logic        phase2_pwm_end_in,
  input  wire logic        phase1_sense_pin_over_in,
  input  wire logic        phase2_sense_pin_over_in,
  input  wire logic        overvoltage_setting_trip_in,
  input  wire logic        feedback_node_uv_in,
  input  wire logic        ss_done_in,
  input  wire logic        ss_empty_in,
  output logic             high_side_drive1_out,
  output logic             low_side_drive1_out,
  output logic             high_side_drive2_out,
  output logic             low_side_drive2_out,
  output logic             pwm_term1_out,
  output logic             pwm_term2_out,
  output logic             power_good_out,
  output logic             sense_test_out,
  output logic             ss_charge_out,
  output logic             ss_discharge_out,
  output logic             sense_fault_flag_out
);

  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offs);
    reg_hit = (addr == offs);
  endfunction

  // ==========================================================================
  // Declarations
  bfps_pkg::bfps_state_e state_r, state_nxt;
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [15:0] period_r, period_nxt;
  logic [4:0]  events_r, events_nxt;
  logic [31:0] rdata_nxt;
  logic        wait_nxt;
  logic [5:0]  sense_cnt_r, sense_cnt_nxt;
  logic [2:0]  hic_cnt_r, hic_cnt_nxt;
  logic [7:0]  en_low_cnt_r, en_low_cnt_nxt;
  logic        enable_r, enable_nxt;
  logic        en_pin_d_r;
  logic [15:0] per_cnt_r, per_cnt_nxt;
  logic [3:0]  edge_cnt_r, edge_cnt_nxt;
  logic        hs1_nxt, ls1_nxt, hs2_nxt, ls2_nxt;
  logic        pg_nxt, test_nxt, chg_nxt, dis_nxt, sf_nxt;
  logic        por_ok, gate_ok, switching, sync_fall, start1, start2;
  logic        hs_on1, hs_on2;
  logic [31:0] rd_mux;
  logic [4:0]  evt_set, evt_clr;

  assign por_ok    = device_supply_rail_ok_in & bypass_supply_rail_ok_in;
  assign gate_ok   = enable_r & ctrl_r[bfps_pkg::CTRL_RUN_BIT] & por_ok;
  assign switching = (state_r == bfps_pkg::ST_SOFT) || (state_r == bfps_pkg::ST_RUN);
  assign sync_fall = en_pin_d_r & ~en_sync_in;
  assign start1    = switching && (per_cnt_r == 16'h0000);
  assign start2    = switching && (per_cnt_r == {1'b0, period_r[15:1]}); // RULE17

  // ==========================================================================
  // Phase channels
  bfps_phase u_phase1 (
    .ref_clk_in    (ref_clk_in),
    .nrst_in       (nrst_in),
    .start_in      (start1),
    .switch_in     (switching),
    .over_limit_in (phase1_over_limit_in),
    .pwm_end_in    (phase1_pwm_end_in),
    .hs_on_out     (hs_on1),
    .term_out      (pwm_term1_out)
  );

  bfps_phase u_phase2 (
    .ref_clk_in    (ref_clk_in),
    .nrst_in       (nrst_in),
    .start_in      (start2),
    .switch_in     (switching),
    .over_limit_in (phase2_over_limit_in),
    .pwm_end_in    (phase2_pwm_end_in),
    .hs_on_out     (hs_on2),
    .term_out      (pwm_term2_out)
  );

  // ==========================================================================
  // Register slave
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(avs_address_in, bfps_pkg::REG_CTRL)) begin
      rd_mux[7:0] = ctrl_r;
    end else if (reg_hit(avs_address_in, bfps_pkg::REG_PERIOD)) begin
      rd_mux[15:0] = period_r;
    end else if (reg_hit(avs_address_in, bfps_pkg::REG_STATUS)) begin
      rd_mux[7:0] = state_r;
      rd_mux[bfps_pkg::STAT_CNT_LSB +: 3] = hic_cnt_r;
      rd_mux[bfps_pkg::STAT_PG_BIT] = power_good_out;
      rd_mux[bfps_pkg::STAT_EN_BIT] = enable_r;
    end else if (reg_hit(avs_address_in, bfps_pkg::REG_EVENTS)) begin
      rd_mux[4:0] = events_r;
    end
    evt_set = 5'h00;
    evt_set[bfps_pkg::EVT_OC1_BIT] = pwm_term1_out;
    evt_set[bfps_pkg::EVT_OC2_BIT] = pwm_term2_out;
    evt_set[bfps_pkg::EVT_OV_BIT]  = switching & overvoltage_setting_trip_in;
    evt_set[bfps_pkg::EVT_UV_BIT]  = (state_r == bfps_pkg::ST_RUN) & feedback_node_uv_in;
    evt_set[bfps_pkg::EVT_SF_BIT]  = sense_fault_flag_out;
    evt_clr    = 5'h00;
    ctrl_nxt   = ctrl_r;
    period_nxt = period_r;
    rdata_nxt  = avs_readdata_out;
    wait_nxt   = 1'b1;
    if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      wait_nxt = 1'b0;
      if (avs_read_in) begin
        rdata_nxt = rd_mux;
      end
    end
    if (avs_write_in && !avs_waitrequest_out) begin
      if (reg_hit(avs_address_in, bfps_pkg::REG_CTRL)) begin
        ctrl_nxt = avs_writedata_in[7:0];
      end else if (reg_hit(avs_address_in, bfps_pkg::REG_PERIOD)) begin
        period_nxt = avs_writedata_in[15:0];
      end else if (reg_hit(avs_address_in, bfps_pkg::REG_EVENTS)) begin
        evt_clr = avs_writedata_in[4:0];
      end
    end
    events_nxt = (events_r & ~evt_clr) | evt_set;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      ctrl_r              <= bfps_pkg::CTRL_RST;
      period_r            <= bfps_pkg::PERIOD_RST;
      events_r            <= 5'h00;
      avs_readdata_out    <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
    end else begin
      ctrl_r              <= ctrl_nxt;
      period_r            <= period_nxt;
      events_r            <= events_nxt;
      avs_readdata_out    <= rdata_nxt;
      avs_waitrequest_out <= wait_nxt;
    end
  end

  // ==========================================================================
  // Enable, sync and phase timing
  always_comb begin
    enable_nxt     = enable_r;
    en_low_cnt_nxt = en_low_cnt_r;
    if (en_sync_in) begin
      enable_nxt     = 1'b1;
      en_low_cnt_nxt = 8'h00;
    end else if (en_low_cnt_r >= bfps_pkg::EN_OFF_CYCLES - 8'h01) begin
      enable_nxt = 1'b0;
    end else begin
      en_low_cnt_nxt = en_low_cnt_r + 8'h01;
    end
    edge_cnt_nxt = edge_cnt_r;
    per_cnt_nxt  = per_cnt_r;
    if (ctrl_r[bfps_pkg::CTRL_SYNC_BIT]) begin
      if (per_cnt_r != 16'hFFFF) begin
        per_cnt_nxt = per_cnt_r + 16'h0001;
      end
      if (sync_fall) begin
        if (edge_cnt_r >= ctrl_r[bfps_pkg::CTRL_DIV_LSB +: 4] - 4'h1) begin
          edge_cnt_nxt = 4'h0;
          per_cnt_nxt  = 16'h0000; // RULE16
        end else begin
          edge_cnt_nxt = edge_cnt_r + 4'h1;
        end
      end
    end else if (per_cnt_r >= period_r - 16'h0001) begin
      per_cnt_nxt = 16'h0000;
    end else begin
      per_cnt_nxt = per_cnt_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_nxt     = state_r;
    sense_cnt_nxt = sense_cnt_r;
    hic_cnt_nxt   = hic_cnt_r;
    sf_nxt        = sense_fault_flag_out;
    if (!gate_ok) begin
      state_nxt = bfps_pkg::ST_OFF; // RULE11
      sf_nxt    = 1'b0;
    end else begin
      case (state_r)
        bfps_pkg::ST_OFF: begin
          state_nxt = bfps_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT;
        end
        bfps_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT: begin
          if (input_undervoltage_lockout_ok_in) begin
            state_nxt     = bfps_pkg::ST_SENSE; // RULE10
            sense_cnt_nxt = 6'h00;
          end
        end
        bfps_pkg::ST_SENSE: begin
          if (!input_undervoltage_lockout_ok_in) begin
            state_nxt = bfps_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT;
          end else if (phase1_sense_pin_over_in || phase2_sense_pin_over_in) begin
            state_nxt = bfps_pkg::ST_SFAULT; // RULE5
            sf_nxt    = 1'b1;
          end else if (sense_cnt_r == bfps_pkg::SENSE_CHECK_CYCLES - 6'h01) begin
            state_nxt = bfps_pkg::ST_SOFT;
          end else begin
            sense_cnt_nxt = sense_cnt_r + 6'h01;
          end
        end
        bfps_pkg::ST_SFAULT: begin
          state_nxt = bfps_pkg::ST_SFAULT; // RULE15
        end
        bfps_pkg::ST_SOFT: begin // RULE13
          if (!input_undervoltage_lockout_ok_in) begin
            state_nxt = bfps_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT;
          end else if (overvoltage_setting_trip_in) begin
            state_nxt = bfps_pkg::ST_HIC_CHG; // RULE8
          end else if (ss_done_in) begin
            state_nxt   = bfps_pkg::ST_RUN; // RULE19
            hic_cnt_nxt = 3'h0; // RULE20
          end
        end
        bfps_pkg::ST_RUN: begin
          if (!input_undervoltage_lockout_ok_in) begin
            state_nxt = bfps_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT;
          end else if (overvoltage_setting_trip_in || feedback_node_uv_in) begin
            state_nxt   = bfps_pkg::ST_HIC_CHG; // RULE3 RULE9
            hic_cnt_nxt = 3'h0;
          end
        end
        bfps_pkg::ST_HIC_CHG: begin
          if (ss_done_in) begin
            state_nxt = bfps_pkg::ST_HIC_DIS;
          end
        end
        bfps_pkg::ST_HIC_DIS: begin
          if (ss_empty_in) begin
            if (hic_cnt_r == bfps_pkg::HICCUP_CYCLES - 3'h1) begin
              state_nxt = bfps_pkg::ST_SOFT; // RULE4
            end else begin
              state_nxt   = bfps_pkg::ST_HIC_CHG;
              hic_cnt_nxt = hic_cnt_r + 3'h1;
            end
          end
        end
        default: begin
          state_nxt = bfps_pkg::ST_OFF;
        end
      endcase
    end
    test_nxt = (state_nxt == bfps_pkg::ST_SENSE); // RULE6
    chg_nxt  = (state_nxt == bfps_pkg::ST_SOFT) || (state_nxt == bfps_pkg::ST_RUN) ||
               (state_nxt == bfps_pkg::ST_HIC_CHG); // RULE18
    dis_nxt  = (state_nxt == bfps_pkg::ST_HIC_DIS) || (state_nxt == bfps_pkg::ST_OFF) ||
               (state_nxt == bfps_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT);
    pg_nxt   = (state_nxt == bfps_pkg::ST_RUN); // RULE12
    if (!gate_ok || state_r == bfps_pkg::ST_OFF || state_r == bfps_pkg::ST_SENSE) begin
      {hs1_nxt, ls1_nxt, hs2_nxt, ls2_nxt} = 4'h0; // RULE21
    end else if (switching && !overvoltage_setting_trip_in) begin
      hs1_nxt = hs_on1;
      ls1_nxt = ~hs_on1;
      hs2_nxt = hs_on2;
      ls2_nxt = ~hs_on2;
    end else begin
      {hs1_nxt, ls1_nxt, hs2_nxt, ls2_nxt} = 4'h5; // RULE7 RULE14
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_r              <= bfps_pkg::ST_OFF;
      sense_cnt_r          <= 6'h00;
      hic_cnt_r            <= 3'h0;
      enable_r             <= 1'b0;
      en_low_cnt_r         <= 8'h00;
      en_pin_d_r           <= 1'b0;
      per_cnt_r            <= 16'h0000;
      edge_cnt_r           <= 4'h0;
      high_side_drive1_out <= 1'b0;
      low_side_drive1_out  <= 1'b0;
      high_side_drive2_out <= 1'b0;
      low_side_drive2_out  <= 1'b0;
      power_good_out       <= 1'b0;
      sense_test_out       <= 1'b0;
      ss_charge_out        <= 1'b0;
      ss_discharge_out     <= 1'b1;
      sense_fault_flag_out <= 1'b0;
    end else begin
      state_r              <= state_nxt;
      sense_cnt_r          <= sense_cnt_nxt;
      hic_cnt_r            <= hic_cnt_nxt;
      enable_r             <= enable_nxt;
      en_low_cnt_r         <= en_low_cnt_nxt;
      en_pin_d_r           <= en_sync_in;
      per_cnt_r            <= per_cnt_nxt;
      edge_cnt_r           <= edge_cnt_nxt;
      high_side_drive1_out <= hs1_nxt;
      low_side_drive1_out  <= ls1_nxt;
      high_side_drive2_out <= hs2_nxt;
      low_side_drive2_out  <= ls2_nxt;
      power_good_out       <= pg_nxt;
      sense_test_out       <= test_nxt;
      ss_charge_out        <= chg_nxt;
      ss_discharge_out     <= dis_nxt;
      sense_fault_flag_out <= sf_nxt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_sense_window_end: assert property ( // RULE5
    gate_ok && input_undervoltage_lockout_ok_in && state_r == bfps_pkg::ST_SENSE && sense_cnt_r == 6'h1F &&
    !phase1_sense_pin_over_in && !phase2_sense_pin_over_in |=> state_r == bfps_pkg::ST_SOFT)
    else $error("sense check did not end after 32 cycles");

  chk_sense_only_init: assert property ( // RULE6
    sense_test_out |-> $past(state_nxt) == bfps_pkg::ST_SENSE && !switching)
    else $error("sense test current outside initialization");

  chk_ov_gates_safe: assert property ( // RULE7
    gate_ok && switching && overvoltage_setting_trip_in |=>
    !high_side_drive1_out && low_side_drive1_out && !high_side_drive2_out && low_side_drive2_out)
    else $error("overvoltage did not force upper off lower on");

  chk_uv_enters_hiccup: assert property ( // RULE9
    gate_ok && input_undervoltage_lockout_ok_in && state_r == bfps_pkg::ST_RUN && feedback_node_uv_in
    |=> state_r == bfps_pkg::ST_HIC_CHG && ss_charge_out && !power_good_out)
    else $error("undervoltage did not start hiccup");

  chk_hiccup_seven: assert property ( // RULE4
    gate_ok && state_r == bfps_pkg::ST_HIC_DIS && ss_empty_in && hic_cnt_r == 3'h6
    |=> state_r == bfps_pkg::ST_SOFT)
    else $error("no restart after seven hiccup cycles");

  chk_masked_no_hiccup: assert property ( // RULE13
    state_r == bfps_pkg::ST_SOFT && !overvoltage_setting_trip_in |=> state_r != bfps_pkg::ST_HIC_CHG)
    else $error("masked state entered hiccup");

  chk_pg_low_masked: assert property ( // RULE12
    state_r == bfps_pkg::ST_SOFT |-> !power_good_out)
    else $error("power good high during soft-start");

  chk_pg_needs_done: assert property ( // RULE19
    $rose(power_good_out) |-> $past(ss_done_in))
    else $error("power good released without soft-start completion");

  chk_off_all_open: assert property ( // RULE21
    !enable_r || !bypass_supply_rail_ok_in |=>
    !high_side_drive1_out && !low_side_drive1_out && !high_side_drive2_out && !low_side_drive2_out)
    else $error("switches not off with enable low or supply lockout");

  chk_input_undervoltage_lockout_hold: assert property ( // RULE14
    gate_ok && state_r == bfps_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT |=> !high_side_drive1_out && low_side_drive1_out)
    else $error("lockout did not hold upper off lower on");

  chk_sfault_hold: assert property ( // RULE15
    gate_ok && state_r == bfps_pkg::ST_SFAULT |=> !high_side_drive2_out && low_side_drive2_out)
    else $error("sense fault did not hold upper off lower on");

  chk_por_blocks: assert property ( // RULE11
    !por_ok |=> state_r == bfps_pkg::ST_OFF ##1 !ss_charge_out)
    else $error("started with rails not good");

  chk_input_undervoltage_lockout_gate: assert property ( // RULE10
    state_r == bfps_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT && !input_undervoltage_lockout_ok_in |=> state_r != bfps_pkg::ST_SENSE)
    else $error("started below input undervoltage threshold");

  chk_hic_clear: assert property ( // RULE20
    gate_ok && input_undervoltage_lockout_ok_in && state_r == bfps_pkg::ST_SOFT && !overvoltage_setting_trip_in
    && ss_done_in |=> hic_cnt_r == 3'h0)
    else $error("hiccup count not cleared on clean completion");

endmodule

// ==== tb/bfps_ss_model.sv ====
// Soft-start node with its comparators, as seen from the sequencer's far side
`timescale 1ns/1ps
module bfps_ss_model (
  input  wire logic ref_clk_in,
  input  wire logic charge_in,
  input  wire logic discharge_in,
  input  wire logic hold_in,
  output logic      done_out,
  output logic      empty_out
);
  logic [3:0] lvl_r;
  initial lvl_r = 4'h0;
  // Hold stands for an external clamp keeping the node below completion
  always @(posedge ref_clk_in) begin
    if (discharge_in && lvl_r != 4'h0) lvl_r <= lvl_r - 4'h1;
    else if (charge_in && !hold_in && lvl_r != 4'hf) lvl_r <= lvl_r + 4'h1;
  end
  assign done_out  = (lvl_r == 4'hf);
  assign empty_out = (lvl_r == 4'h0);
endmodule

// ==== tb/buck_fault_protection_sequencer_tb.sv ====
// Self-checking bench for the buck fault sequencer
`timescale 1ns/1ps
module buck_fault_protection_sequencer_tb;
  logic ref_clk_in = 0, nrst_in = 0, rd = 0, wr = 0, en = 0, dok = 1, bok = 1, uok = 1;
  logic o1 = 0, o2 = 0, e1 = 0, e2 = 0, s1 = 0, s2 = 0, ov = 0, uv = 0, hold = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdata, q, lfsr = 32'h0001_13b8;
  logic wt, h1, l1, h2, l2, t1, t2, pg, st, chg, dis, sff, sdone, sempty, pv;
  int miscompares = 0, comparisons = 0, n;
  always #25 ref_clk_in = ~ref_clk_in;
  bfps_ss_model ssm (.ref_clk_in(ref_clk_in), .charge_in(chg), .discharge_in(dis), .hold_in(hold),
    .done_out(sdone), .empty_out(sempty));
  bfps_sequencer dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
    .en_sync_in(en), .device_supply_rail_ok_in(dok), .bypass_supply_rail_ok_in(bok),
    .input_undervoltage_lockout_ok_in(uok), .phase1_over_limit_in(o1), .phase2_over_limit_in(o2),
    .phase1_pwm_end_in(e1), .phase2_pwm_end_in(e2), .phase1_sense_pin_over_in(s1),
    .phase2_sense_pin_over_in(s2), .overvoltage_setting_trip_in(ov), .feedback_node_uv_in(uv),
    .ss_done_in(sdone), .ss_empty_in(sempty), .high_side_drive1_out(h1), .low_side_drive1_out(l1),
    .high_side_drive2_out(h2), .low_side_drive2_out(l2), .pwm_term1_out(t1), .pwm_term2_out(t2),
    .power_good_out(pg), .sense_test_out(st), .ss_charge_out(chg), .ss_discharge_out(dis),
    .sense_fault_flag_out(sff));
  // ==========================================================================
  // Random end-of-on-time pulses from the modulator side
  always @(posedge ref_clk_in) begin
    lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    e1 <= (lfsr[1:0] == 2'h0);
    e2 <= (lfsr[5:4] == 2'h0);
  end
  // ==========================================================================
  // Checking and closing
  task automatic stop_test();
    $display("compares %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    comparisons++;
    if (v !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen %h expected %h", $time, v, e);
    end
  endtask
  function automatic logic [31:0] drv(input logic a, input logic b, input logic c, input logic d);
    return {28'h000_0000, a, b, c, d};
  endfunction
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do begin @(posedge ref_clk_in); k++; end while (wt !== 1'b0 && k < 20);
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
    @(posedge ref_clk_in);
    if (k >= 20) begin miscompares++; stop_test(); end
  endtask
  task automatic wait_st(input logic [7:0] s);
    int k;
    k = 0;
    do begin bus(1'b0, 4'h8, 32'h0000_0000); k++; end while (q[7:0] !== s && k < 400);
    chk({24'h00_0000, q[7:0]}, {24'h00_0000, s});
    if (k >= 400) stop_test();
  endtask
  task automatic cycles(input int c);
    repeat (c) @(posedge ref_clk_in);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    cycles(3);
    nrst_in <= 1'b1;
    cycles(1);
    bus(1'b0, 4'h0, 0); chk(q, 32'h0000_0081);
    bus(1'b0, 4'h4, 0); chk(q, 32'h0000_0028);
    bus(1'b0, 4'h2, 0); chk(q, 32'h0000_0000);
    n = lfsr[15:0];
    bus(1'b1, 4'h4, n); bus(1'b0, 4'h4, 0); chk(q[15:0], n[15:0]);
    bus(1'b1, 4'h4, 32'h0000_0028);
    uok <= 1'b0; en <= 1'b1; // Startup waits for the undervoltage comparator
    cycles(20); chk(st, 1'b0);
    uok <= 1'b1;
    n = 0; while (st !== 1'b1 && n < 100) begin cycles(1); n++; end
    n = 0; while (st === 1'b1 && n < 100) begin chk(h1 | h2, 1'b0); cycles(1); n++; end
    chk(n, 32);
    chk(pg, 1'b0);
    n = 0; while (pg !== 1'b1 && n < 200) begin cycles(1); n++; end
    chk(pg, 1'b1);
    chk(sdone, 1'b1);
    wait_st(8'h20);
    // Phase two must rise half a period after phase one
    n = 0; while (h1 !== 1'b0 && n < 100) begin cycles(1); n++; end
    n = 0; while (h1 !== 1'b1 && n < 100) begin cycles(1); n++; end
    n = 0; pv = 1'b1;
    while ((h2 !== 1'b1 || pv !== 1'b0) && n < 100) begin pv = h2; cycles(1); n++; end
    chk(n, 20);
    // Sync mode, every falling edge restarts phase one
    bus(1'b1, 4'h0, 32'h0000_0013); cycles(40);
    en <= 1'b0; cycles(1); en <= 1'b1;
    n = 0; while (h1 !== 1'b1 && n < 100) begin cycles(1); n++; end
    chk(n, 3);
    bus(1'b1, 4'h0, 32'h0000_0081);
    o1 <= 1'b1; n = 0;
    while (t1 !== 1'b1 && n < 200) begin chk(t2, 1'b0); cycles(1); n++; end
    chk(t1, 1'b1);
    o2 <= 1'b1; n = 0;
    while (t2 !== 1'b1 && n < 200) begin cycles(1); n++; end
    chk(t2, 1'b1);
    o1 <= 1'b0; o2 <= 1'b0;
    bus(1'b0, 4'hC, 0); chk(q[1:0], 2'h3);
    bus(1'b1, 4'hC, 32'h0000_0003); bus(1'b0, 4'hC, 0); chk(q[1:0], 2'h0);
    ov <= 1'b1; cycles(3); chk(drv(h1, l1, h2, l2), 32'h5);
    wait_st(8'h40); ov <= 1'b0;
    wait_st(8'h10);
    wait_st(8'h20); chk(pg, 1'b1);
    chk(q[10:8], 3'h0);
    uv <= 1'b1; wait_st(8'h40); chk(drv(pg, l1, h1, 1'b0), 32'h4);
    uv <= 1'b0; wait_st(8'h10); hold <= 1'b1;
    uv <= 1'b1; o1 <= 1'b1; cycles(100);
    bus(1'b0, 4'h8, 0); chk(q[7:0], 8'h10); chk(pg, 1'b0);
    uv <= 1'b0; o1 <= 1'b0; hold <= 1'b0;
    uok <= 1'b0; wait_st(8'h02); cycles(2); chk(drv(h1, l1, h2, l2), 32'h5);
    en <= 1'b0; cycles(60); chk(drv(h1, l1, h2, l2), 32'h0);
    s2 <= 1'b1; uok <= 1'b1; en <= 1'b1;
    wait_st(8'h08); cycles(2); chk(sff, 1'b1); chk(drv(h1, l1, h2, l2), 32'h5);
    stop_test();
  end
endmodule
